// [monitor_params.svh]
// How it works
// - mask bits 2,1,0 set to 1 block fan one, board temp, temp; reset 0
// - bit 7 gives shared pin reset-output; bits 7,6 both zero disable it
// - bit 6 selects over-temperature output only while bit 7 is zero
// - level mode, bit 4 set: fan two active low, low level latches status and interrupt until status read
// - level mode, bit 4 clear: fan two active high, high level latches status and interrupt until status read
`ifndef MONITOR_PARAMS_SVH
`define MONITOR_PARAMS_SVH

// ==========================================================
// register offsets
`define STATUS_OFFSET      8'h01
`define IRQ_MASK_OFFSET    8'h03
`define PIN_CFG_OFFSET     8'h05

// ==========================================================
// field positions
`define MASK_TEMP_BIT      0
`define MASK_BOARD_BIT     1
`define MASK_FAN_ONE_BIT   2
`define MASK_FAN_TWO_BIT   3
`define CFG_FAN_ONE_MODE   0
`define CFG_FAN_TWO_MODE   1
`define CFG_PRESCALE_LO    4
`define CFG_PRESCALE_HI    5
`define CFG_POLARITY_BIT   4
`define CFG_OVERTEMP_EN    6
`define CFG_RESET_EN       7

// ==========================================================
// reset values
`define IRQ_MASK_RESET     8'h00
`define PIN_CFG_RESET      8'h10
`define STATUS_RESET       4'h0

// ==========================================================
// bus constants
`define BYTE_BITS          4'h8
`define DEV_ADDR_DEFAULT   7'h2D

`endif

// [monitor_pkg.sv]
package monitor_pkg;

  // ========================================================
  // serial slave states
  typedef enum logic [3:0] {
    ST_IDLE      = 4'b0000,
    ST_ADDR      = 4'b0001,
    ST_ADDR_ACK  = 4'b0010,
    ST_PTR       = 4'b0011,
    ST_PTR_ACK   = 4'b0100,
    ST_WDATA     = 4'b0101,
    ST_WDATA_ACK = 4'b0110,
    ST_RDATA     = 4'b0111,
    ST_RDATA_ACK = 4'b1000,
    ST_WAIT      = 4'b1001
  } slave_state_t;

  typedef logic [1:0] prescale_code_t;

endpackage

// [tach_if.sv]
`timescale 1ns/10ps
interface tach_if;
  import monitor_pkg::*;
  logic           count_en;
  prescale_code_t code;
  logic           tach;
  logic           pulse;

  modport ctrl (output count_en, output code, output tach, input pulse);
  modport div  (input count_en, input code, input tach, output pulse);
endinterface

// [tach_prescaler.sv]
`timescale 1ns/10ps
`include "monitor_params.svh"
module tach_prescaler
  import monitor_pkg::*;
(
  input  wire logic ref_clk_in, // system clock
  input  wire logic rst_in,     // sync reset, active high
  tach_if.div       tif         // prescale control and tach
);

  // ========================================================
  // divide ratio decode
  function automatic logic [2:0] last_count(input prescale_code_t c);
    case (c)
      2'h0:    last_count = 3'h0;
      2'h1:    last_count = 3'h1;
      2'h2:    last_count = 3'h3;
      default: last_count = 3'h7;
    endcase
  endfunction

  logic       tach_prev_reg;
  logic [2:0] count_reg;
  logic       pulse_reg;

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      tach_prev_reg <= 1'b0;
    end else begin
      tach_prev_reg <= tif.tach;
    end
  end

  // one pulse per 1, 2, 4 or 8 rising tach edges
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || !tif.count_en) begin
      count_reg <= 3'h0;
      pulse_reg <= 1'b0;
    end else if (tif.tach && !tach_prev_reg) begin
      if (count_reg >= last_count(tif.code)) begin
        count_reg <= 3'h0;
        pulse_reg <= 1'b1;
      end else begin
        count_reg <= count_reg + 3'h1;
        pulse_reg <= 1'b0;
      end
    end else begin
      pulse_reg <= 1'b0;
    end
  end

  assign tif.pulse = pulse_reg;

endmodule // tach_prescaler

// [monitor_irq_mask_pin_config.sv]
`timescale 1ns/10ps
`include "monitor_params.svh"
module monitor_irq_mask_pin_config
  import monitor_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT // arbitrary value
) (
  input  wire logic ref_clk_in,          // system clock, 100 MHz
  input  wire logic rst_in,              // sync reset, active high
  input  wire logic scl_in,              // serial clock level
  input  wire logic sda_in,              // serial data level
  output logic      sda_out,             // serial data drive value
  output logic      sda_oe_n_out,        // low while pulling data low
  input  wire logic temp_alert_in,       // temperature event
  input  wire logic board_temp_alert_in, // board temperature event
  input  wire logic fan_one_alarm_in,    // fan one event
  input  wire logic fan_speed_in_two,    // fan two tach or level
  input  wire logic reset_request_in,    // reset-output request
  input  wire logic overtemp_in,         // over-temperature condition
  output logic      shared_pin_out,      // shared pin drive value
  output logic      shared_pin_oe_n_out, // low while shared pin driven
  output logic      irq_out,             // interrupt, active high
  output logic      fan_two_tach_out     // prescaled fan two pulse
);

  // ========================================================
  // register address decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  slave_state_t state_reg;
  logic [7:0]   shift_reg;
  logic [3:0]   bit_cnt_reg;
  logic [7:0]   ptr_reg;
  logic         scl_prev_reg;
  logic         sda_prev_reg;
  logic         sda_oe_n_reg;
  logic         wr_pulse;
  logic         rd_pulse;
  logic [7:0]   rdata;
  logic [7:0]   mask_reg;
  logic [7:0]   pin_cfg_reg;
  logic [3:0]   status_reg;
  logic [3:0]   status_set;
  logic         level_mode;
  logic         fan_two_alarm;
  logic         shared_oe_n_reg;
  logic         irq_reg;
  logic         tach_pulse_reg;
  tach_if       tif ();

  // ========================================================
  // serial bus edges
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= scl_in;
      sda_prev_reg <= sda_in;
    end
  end

  wire scl_rise = scl_in && !scl_prev_reg;
  wire scl_fall = !scl_in && scl_prev_reg;
  wire start_c  = scl_in && scl_prev_reg && sda_prev_reg && !sda_in;
  wire stop_c   = scl_in && scl_prev_reg && !sda_prev_reg && sda_in;
  wire byte_end = (bit_cnt_reg == `BYTE_BITS);

  assign wr_pulse = scl_fall && (state_reg == ST_WDATA) && byte_end;
  assign rd_pulse = scl_fall && shift_reg[0] &&
                    (state_reg == ST_ADDR_ACK || state_reg == ST_RDATA_ACK);

  // ========================================================
  // serial slave sequencer
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || stop_c) begin
      state_reg    <= ST_IDLE;
      bit_cnt_reg  <= 4'h0;
      shift_reg    <= 8'h00;
      sda_oe_n_reg <= 1'b1;
    end else if (start_c) begin
      state_reg    <= ST_ADDR;
      bit_cnt_reg  <= 4'h0;
      sda_oe_n_reg <= 1'b1;
    end else if (scl_rise) begin
      case (state_reg)
        ST_ADDR, ST_PTR, ST_WDATA: begin
          shift_reg   <= {shift_reg[6:0], sda_in};
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
        ST_RDATA: begin
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
        ST_RDATA_ACK: begin
          shift_reg[0] <= !sda_in;
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (state_reg)
        ST_ADDR: begin
          if (byte_end && shift_reg[7:1] == DEV_ADDR) begin
            state_reg    <= ST_ADDR_ACK;
            sda_oe_n_reg <= 1'b0;
          end else if (byte_end) begin
            state_reg <= ST_WAIT;
          end
        end
        ST_PTR, ST_WDATA: begin
          if (byte_end) begin
            state_reg    <= (state_reg == ST_PTR) ? ST_PTR_ACK : ST_WDATA_ACK;
            sda_oe_n_reg <= 1'b0;
          end
        end
        ST_ADDR_ACK, ST_RDATA_ACK: begin
          bit_cnt_reg <= 4'h0;
          if (shift_reg[0]) begin
            state_reg    <= ST_RDATA;
            shift_reg    <= rdata;
            sda_oe_n_reg <= rdata[7];
          end else begin
            state_reg    <= (state_reg == ST_ADDR_ACK) ? ST_PTR : ST_WAIT;
            sda_oe_n_reg <= 1'b1;
          end
        end
        ST_PTR_ACK, ST_WDATA_ACK: begin
          state_reg    <= ST_WDATA;
          bit_cnt_reg  <= 4'h0;
          sda_oe_n_reg <= 1'b1;
        end
        ST_RDATA: begin
          if (byte_end) begin
            state_reg    <= ST_RDATA_ACK;
            sda_oe_n_reg <= 1'b1;
          end else begin
            shift_reg    <= {shift_reg[6:0], 1'b0};
            sda_oe_n_reg <= shift_reg[6];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ========================================================
  // register pointer
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      ptr_reg <= 8'h00;
    end else if (scl_fall && state_reg == ST_PTR && byte_end) begin
      ptr_reg <= shift_reg;
    end
  end

  // ========================================================
  // configuration registers
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      mask_reg    <= `IRQ_MASK_RESET;
      pin_cfg_reg <= `PIN_CFG_RESET;
    end else if (wr_pulse) begin
      if (hit(ptr_reg, `IRQ_MASK_OFFSET)) begin
        mask_reg <= shift_reg;
      end
      if (hit(ptr_reg, `PIN_CFG_OFFSET)) begin
        pin_cfg_reg <= shift_reg;
      end
    end
  end

  always_comb begin
    rdata = 8'h00;
    if (hit(ptr_reg, `IRQ_MASK_OFFSET)) begin
      rdata = mask_reg;
    end else if (hit(ptr_reg, `PIN_CFG_OFFSET)) begin
      rdata = pin_cfg_reg;
    end else if (hit(ptr_reg, `STATUS_OFFSET)) begin
      rdata = {4'h0, status_reg};
    end
  end

  // ========================================================
  // status and interrupt
  assign level_mode    = pin_cfg_reg[`CFG_FAN_TWO_MODE];
  assign fan_two_alarm = level_mode &&
    (pin_cfg_reg[`CFG_POLARITY_BIT] ? !fan_speed_in_two
                                    : fan_speed_in_two);
  assign status_set = {fan_two_alarm, fan_one_alarm_in,
                       board_temp_alert_in, temp_alert_in};

  // a new event wins over the clear-on-read
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      status_reg <= `STATUS_RESET;
    end else if (rd_pulse && hit(ptr_reg, `STATUS_OFFSET)) begin
      status_reg <= status_set;
    end else begin
      status_reg <= status_reg | status_set;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(status_reg & ~mask_reg[3:0]);
    end
  end

  // ========================================================
  // shared reset-output / over-temperature pin, open drain
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      shared_oe_n_reg <= 1'b1;
    end else if (pin_cfg_reg[`CFG_RESET_EN]) begin
      shared_oe_n_reg <= !reset_request_in;
    end else if (pin_cfg_reg[`CFG_OVERTEMP_EN]) begin
      shared_oe_n_reg <= !overtemp_in;
    end else begin
      shared_oe_n_reg <= 1'b1;
    end
  end

  // ========================================================
  // fan two prescaler
  assign tif.count_en = !level_mode;
  assign tif.code     = pin_cfg_reg[`CFG_PRESCALE_HI:`CFG_PRESCALE_LO];
  assign tif.tach     = fan_speed_in_two;

  tach_prescaler u_prescaler (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .tif        (tif.div)
  );

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      tach_pulse_reg <= 1'b0;
    end else begin
      tach_pulse_reg <= tif.pulse;
    end
  end

  // ========================================================
  // outputs
  assign sda_out             = 1'b0;
  assign sda_oe_n_out        = sda_oe_n_reg;
  assign shared_pin_out      = 1'b0;
  assign shared_pin_oe_n_out = shared_oe_n_reg;
  assign irq_out             = irq_reg;
  assign fan_two_tach_out    = tach_pulse_reg;

endmodule // monitor_irq_mask_pin_config

// [monitor_irq_mask_pin_config_chk.sv]
`timescale 1ns/10ps
module monitor_irq_mask_pin_config_chk (
  input wire logic ref_clk_in,          // clock
  input wire logic rst_in,              // reset
  input wire logic scl_in,              // serial clock
  input wire logic sda_oe_n_out,        // data drive
  input wire logic fan_speed_in_two,    // fan two input
  input wire logic reset_request_in,    // reset request
  input wire logic overtemp_in,         // over-temperature
  input wire logic shared_pin_oe_n_out, // shared pin drive
  input wire logic irq_out,             // interrupt
  input wire logic fan_two_tach_out     // prescaled pulse
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  logic       tach_prev_reg;
  logic [2:0] age_reg;
  // =========================================
  // cycles since the last rising tach edge
  always_ff @(posedge ref_clk_in) begin
    tach_prev_reg <= fan_speed_in_two;
  end
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) age_reg <= 3'h7;
    else if (fan_speed_in_two && !tach_prev_reg) age_reg <= 3'h0;
    else if (age_reg != 3'h7) age_reg <= age_reg + 3'h1;
  end
  // =========================================
  // assertions
  a_reset_idle_out: assert property ($fell(rst_in) |-> sda_oe_n_out
    && shared_pin_oe_n_out && !irq_out && !fan_two_tach_out)
    else $error("outputs not idle after reset");
  a_pin_needs_cause: assert property (!shared_pin_oe_n_out |->
    $past(reset_request_in) || $past(overtemp_in))
    else $error("shared pin driven without cause");
  a_pin_released: assert property (!reset_request_in && !overtemp_in
    |=> shared_pin_oe_n_out)
    else $error("shared pin driven with no request");
  a_tach_single: assert property (fan_two_tach_out |=> !fan_two_tach_out)
    else $error("tach pulse longer than one cycle");
  a_tach_near_edge: assert property (fan_two_tach_out |-> age_reg <= 3'h4)
    else $error("tach pulse without recent edge");
  a_data_scl_low: assert property ($changed(sda_oe_n_out) |-> !scl_in)
    else $error("data drive changed while clock high");
  c_irq: cover property ($rose(irq_out));
  c_pin: cover property (!shared_pin_oe_n_out);
  c_tach: cover property (fan_two_tach_out);
endmodule // monitor_irq_mask_pin_config_chk

// [host_model.sv]
`timescale 1ns/10ps
`include "monitor_params.svh"
module host_model (
  input  wire logic ref_clk_in, // clock
  input  wire logic sda_in,     // resolved data wire
  output logic      scl_out,    // serial clock
  output logic      sda_rel_out // 1 releases data
);
  initial begin
    scl_out = 1'b1;
    sda_rel_out = 1'b1;
  end
  // =========================================
  // bus phases
  task automatic hp(input int n);
    repeat (n) @(negedge ref_clk_in);
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_rel_out = b;
    hp(2);
    scl_out = 1'b1;
    hp(3);
    r = sda_in;
    scl_out = 1'b0;
    hp(2);
  endtask
  task automatic byte_io(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) bit_io(d[i], q[i]);
  endtask
  task automatic start_c;
    sda_rel_out = 1'b1;
    hp(2);
    scl_out = 1'b1;
    hp(3);
    sda_rel_out = 1'b0;
    hp(3);
    scl_out = 1'b0;
    hp(2);
  endtask
  // pointer then data, or pointer then repeated start and one read
  task automatic acc(input logic rd, input logic [7:0] p,
                     input logic [7:0] v, output logic [7:0] q);
    logic [8:0] b;
    start_c;
    byte_io({`DEV_ADDR_DEFAULT, 1'b0, 1'b1}, b);
    byte_io({p, 1'b1}, b);
    if (rd) begin
      start_c;
      byte_io({`DEV_ADDR_DEFAULT, 1'b1, 1'b1}, b);
      byte_io(9'h1FF, b);
    end else byte_io({v, 1'b1}, b);
    q = b[8:1];
    sda_rel_out = 1'b0;
    hp(2);
    scl_out = 1'b1;
    hp(3);
    sda_rel_out = 1'b1;
    hp(3);
  endtask
endmodule // host_model

// [monitor_irq_mask_pin_config_test.sv]
`timescale 1ns/10ps
`include "monitor_params.svh"
module monitor_irq_mask_pin_config_test;
  logic       ref_clk_in, rst_in, scl, sda_rel, sda_oe_n, sda_w;
  logic       req, ot, fan2, pin_oe_n, irq, tach_p, e, sda_o, pin_o;
  logic [2:0] ev;
  logic [7:0] rv;
  logic [7:0] pcfg [4] = '{8'h80, 8'hC0, 8'h40, 8'h00};
  int         miscompares, tests_run, cyc, pulses;
  assign sda_w = sda_rel & (sda_oe_n | sda_o);
  monitor_irq_mask_pin_config i_dut (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .scl_in(scl),
    .sda_in(sda_w), .sda_out(sda_o), .sda_oe_n_out(sda_oe_n),
    .temp_alert_in(ev[0]), .board_temp_alert_in(ev[1]),
    .fan_one_alarm_in(ev[2]), .fan_speed_in_two(fan2),
    .reset_request_in(req), .overtemp_in(ot), .shared_pin_out(pin_o),
    .shared_pin_oe_n_out(pin_oe_n), .irq_out(irq),
    .fan_two_tach_out(tach_p));
  host_model i_host (.ref_clk_in(ref_clk_in), .sda_in(sda_w),
    .scl_out(scl), .sda_rel_out(sda_rel));
  // =========================================
  // checks and verdict
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_rd(input logic [7:0] p, input logic [7:0] x);
    i_host.acc(1'b1, p, 8'h00, rv);
    cmp(rv, x);
  endtask
  task automatic print_verdict;
    if (miscompares == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clk_in) begin
    cyc++;
    if (tach_p === 1'b1) pulses++;
    if (cyc == 40000) begin
      miscompares++;
      print_verdict;
    end
  end
  // =========================================
  // main sequence
  initial begin
    rst_in = 1'b1;
    req = 1'b0;
    ot = 1'b0;
    fan2 = 1'b0;
    ev = 3'h0;
    repeat (20) @(negedge ref_clk_in);
    rst_in = 1'b0;
    chk_rd(`IRQ_MASK_OFFSET, 8'h00);
    chk_rd(`PIN_CFG_OFFSET, 8'h10);
    for (int i = 0; i < 3; i++) begin
      i_host.acc(1'b0, `IRQ_MASK_OFFSET, 8'h07, rv);
      ev[i] = 1'b1;
      i_host.hp(2);
      ev[i] = 1'b0;
      i_host.hp(4);
      cmp({7'h0, irq}, 8'h00);
      i_host.acc(1'b0, `IRQ_MASK_OFFSET, 8'h00, rv);
      cmp({7'h0, irq}, 8'h01);
      chk_rd(`STATUS_OFFSET, 8'h01 << i);
      i_host.hp(4);
      cmp({7'h0, irq}, 8'h00);
    end
    for (int c = 0; c < 4; c++) begin
      i_host.acc(1'b0, `PIN_CFG_OFFSET, pcfg[c], rv);
      chk_rd(`PIN_CFG_OFFSET, pcfg[c]);
      for (int j = 0; j < 2; j++) begin
        req = (j == 0);
        ot = (j == 1);
        e = ~(pcfg[c][7] ? req : pcfg[c][6] & ot);
        i_host.hp(3);
        cmp({7'h0, pin_oe_n}, {7'h0, e});
        cmp({6'h0, sda_o, pin_o}, 8'h00);
      end
      req = 1'b0;
      ot = 1'b0;
    end
    // level mode: drive the inactive level, then pulse the active one
    for (int p = 1; p >= 0; p--) begin
      fan2 = p[0];
      i_host.acc(1'b0, `PIN_CFG_OFFSET, {3'h0, p[0], 4'h2}, rv);
      i_host.acc(1'b1, `STATUS_OFFSET, 8'h00, rv);
      i_host.hp(3);
      cmp({7'h0, irq}, 8'h00);
      fan2 = ~p[0];
      i_host.hp(4);
      fan2 = p[0];
      cmp({7'h0, irq}, 8'h01);
      chk_rd(`STATUS_OFFSET, 8'h08);
    end
    fan2 = 1'b0;
    for (int c = 0; c < 4; c++) begin
      i_host.acc(1'b0, `PIN_CFG_OFFSET, {2'h0, c[1:0], 4'h0}, rv);
      pulses = 0;
      repeat (16) begin
        fan2 = 1'b1;
        i_host.hp(4);
        fan2 = 1'b0;
        i_host.hp(4);
      end
      cmp(pulses[7:0], 8'h10 >> c);
    end
    print_verdict;
  end
endmodule // monitor_irq_mask_pin_config_test
bind monitor_irq_mask_pin_config monitor_irq_mask_pin_config_chk i_chk (.*);
